// File: rdw_pkg.sv
// shared constants and types for the receive descriptor status word writer
package rdw_pkg;

  // register byte offsets on the wishbone bus
  localparam logic [3:0] OFF_CTRL      = 4'h0;
  localparam logic [3:0] OFF_STATS     = 4'h4;
  localparam logic [3:0] OFF_LAST_WORD = 4'h8;

  // control register fields and reset value
  localparam int          CTRL_ENABLE_BIT  = 0;
  localparam int          CTRL_IPC_T1_BIT  = 1;
  localparam int          CTRL_THRESH_BIT  = 2;
  localparam int          CTRL_WIDTH       = 3;
  localparam logic [2:0]  CTRL_RESET       = 3'h0;

  // status word bit positions
  localparam int OWN_BIT      = 31;
  localparam int DA_FAIL_BIT  = 30;
  localparam int LEN_MSB      = 29;
  localparam int LEN_LSB      = 16;
  localparam int ERR_ANY_BIT  = 15;
  localparam int TRUNC_BIT    = 14;
  localparam int SA_FAIL_BIT  = 13;
  localparam int LEN_ERR_BIT  = 12;
  localparam int OVF_BIT      = 11;
  localparam int VLAN_BIT     = 10;
  localparam int FIRST_BIT    = 9;
  localparam int LAST_BIT     = 8;
  localparam int GIANT_BIT    = 7;
  localparam int LATE_COL_BIT = 6;
  localparam int ETYPE_BIT    = 5;
  localparam int WDOG_BIT     = 4;
  localparam int RX_ERR_BIT   = 3;
  localparam int CRC_BIT      = 1;

  // field widths and decode thresholds
  localparam int           LEN_W           = 14;
  localparam int           BS_W            = 13;
  localparam logic [15:0]  ETHERTYPE_MIN   = 16'h0600;
  localparam logic [13:0]  IPC_T1_EXTRA    = 14'h0002;
  localparam logic [13:0]  LEN_ONE         = 14'h0001;
  localparam logic [15:0]  STAT_ONE        = 16'h0001;

  // fields that make up status word zero
  typedef struct packed {
    logic              own;
    logic              da_fail;
    logic [LEN_W-1:0]  len;
    logic              trunc;
    logic              sa_fail;
    logic              len_err;
    logic              ovf;
    logic              vlan;
    logic              first;
    logic              last;
    logic              giant;
    logic              late_col;
    logic              etype;
    logic              wdog;
    logic              rx_err;
    logic              crc;
    logic              ip_hdr;
    logic              ip_pay;
  } rdw_fields_t;

endpackage

// File: rdw_cfg_if.sv
// configuration and statistics carried between register file and core
`timescale 1ns/1ps
interface rdw_cfg_if;
  logic        enable;
  logic        ipc_type1;
  logic        threshold_mode;
  logic [15:0] frames_done;
  logic [15:0] trunc_count;
  logic [31:0] last_word;

  modport regs (output enable, output ipc_type1, output threshold_mode,
                input frames_done, input trunc_count, input last_word);
  modport core (input enable, input ipc_type1, input threshold_mode,
                output frames_done, output trunc_count, output last_word);
endinterface

// File: rdw_word_pack.sv
// places the status fields into word zero and forms the error summary
`timescale 1ns/1ps
module rdw_word_pack (
  input  rdw_pkg::rdw_fields_t f_i,
  output logic [31:0]          word_o
);

  // the summary is forced low outside the last descriptor so software never sees a stale one
  function automatic logic err_any(input rdw_pkg::rdw_fields_t f);
    return f.last & (f.crc | f.rx_err | f.wdog | f.late_col | f.giant |
                     f.ip_hdr | f.ip_pay | f.ovf | f.trunc);
  endfunction

  // bit placement; bits 2 and 0 belong to other logic and read zero here
  always_comb begin
    word_o                                     = 32'h0000_0000;
    word_o[rdw_pkg::OWN_BIT]                   = f_i.own;
    word_o[rdw_pkg::DA_FAIL_BIT]               = f_i.da_fail;
    word_o[rdw_pkg::LEN_MSB:rdw_pkg::LEN_LSB]  = f_i.len;
    word_o[rdw_pkg::ERR_ANY_BIT]               = err_any(f_i);
    word_o[rdw_pkg::TRUNC_BIT]                 = f_i.trunc;
    word_o[rdw_pkg::SA_FAIL_BIT]               = f_i.sa_fail;
    word_o[rdw_pkg::LEN_ERR_BIT]               = f_i.len_err;
    word_o[rdw_pkg::OVF_BIT]                   = f_i.ovf;
    word_o[rdw_pkg::VLAN_BIT]                  = f_i.vlan;
    word_o[rdw_pkg::FIRST_BIT]                 = f_i.first;
    word_o[rdw_pkg::LAST_BIT]                  = f_i.last;
    word_o[rdw_pkg::GIANT_BIT]                 = f_i.giant;
    word_o[rdw_pkg::LATE_COL_BIT]              = f_i.late_col;
    word_o[rdw_pkg::ETYPE_BIT]                 = f_i.etype;
    word_o[rdw_pkg::WDOG_BIT]                  = f_i.wdog;
    word_o[rdw_pkg::RX_ERR_BIT]                = f_i.rx_err;
    word_o[rdw_pkg::CRC_BIT]                   = f_i.crc;
  end

endmodule // rdw_word_pack

// File: rdw_wb_regs.sv
// classic wishbone slave holding control and showing core statistics
`timescale 1ns/1ps
module rdw_wb_regs (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  rdw_cfg_if.regs          cfg
);

  typedef struct packed {
    logic [rdw_pkg::CTRL_WIDTH-1:0] ctrl;
    logic                           ack;
    logic [31:0]                    dat;
  } rdw_regs_state_t;

  rdw_regs_state_t s_reg;
  rdw_regs_state_t s_next;
  logic            req;

  // ack is withheld in the cycle after an answer, so one access is taken exactly once
  assign req = wb_cyc_i & wb_stb_i & ~s_reg.ack;

  // decode, write and read; unmapped addresses ack with zero data and drop writes
  always_comb begin
    s_next     = s_reg;
    s_next.ack = req;
    if (req) begin
      s_next.dat = 32'h0000_0000;
      unique case (wb_adr_i)
        rdw_pkg::OFF_CTRL: begin
          if (wb_we_i && wb_sel_i[0]) begin
            s_next.ctrl = wb_dat_i[rdw_pkg::CTRL_WIDTH-1:0];
          end
          s_next.dat[rdw_pkg::CTRL_WIDTH-1:0] = s_reg.ctrl;
        end
        rdw_pkg::OFF_STATS:     s_next.dat = {cfg.trunc_count, cfg.frames_done};
        rdw_pkg::OFF_LAST_WORD: s_next.dat = cfg.last_word;
        default:                s_next.dat = 32'h0000_0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg.ctrl <= rdw_pkg::CTRL_RESET;
      s_reg.ack  <= 1'b0;
      s_reg.dat  <= 32'h0000_0000;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_ack_o           = s_reg.ack;
  assign wb_dat_o           = s_reg.dat;
  assign cfg.enable         = s_reg.ctrl[rdw_pkg::CTRL_ENABLE_BIT];
  assign cfg.ipc_type1      = s_reg.ctrl[rdw_pkg::CTRL_IPC_T1_BIT];
  assign cfg.threshold_mode = s_reg.ctrl[rdw_pkg::CTRL_THRESH_BIT];

  a_wb_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

endmodule // rdw_wb_regs

// File: rdw_status_core.sv
// receive descriptor status word writer: ownership, length, filters, errors
//
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/1ps

// Notes on behaviour
// - set ownership bit hands descriptor to dma; clear means host owns, unused
// - ownership cleared on frame end or when descriptor buffers fill
// - destination filter failure reported in bit 30
// - bits 29:16 count frame bytes moved to memory, crc included
// - length is final only in the last descriptor, absent truncation or overflow
// - type 1 checksum adds two bytes to length for non control frames
// - non-last descriptors carry the running byte count of the frame
// - bit 15 is the or of all listed error flags
// - error summary meaningful only in the last descriptor
// - truncation flag when frame overflows buffers and next descriptor not owned
// - source filter failure reported in bit 13
// - length mismatch flag, meaningful only for length encoded frames
// - overflow flag only for partial frames in threshold mode
// - store and forward mode drops overflowed frames entirely; here only frames ending in their first descriptor are dropped
// - vlan tagged frame reported in bit 10
// - first buffer flag marks the descriptor where the frame starts
// - zero sized buffers are skipped; both zero moves to next descriptor
// - last buffer flag marks the descriptor holding the frame's end
// - bit 5 set when length/type is at least 0x0600
module rdw_status_core (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [3:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  output logic                           desc_ready_o,
  input  wire logic                      desc_valid_i,
  input  wire logic                      desc_own_i,
  input  wire logic [rdw_pkg::BS_W-1:0]  desc_bs1_i,
  input  wire logic [rdw_pkg::BS_W-1:0]  desc_bs2_i,
  input  wire logic                      rx_valid_i,
  output logic                           rx_ready_o,
  input  wire logic                      rx_last_i,
  input  wire logic                      st_da_fail_i,
  input  wire logic                      st_sa_fail_i,
  input  wire logic                      st_crc_err_i,
  input  wire logic                      st_rx_err_i,
  input  wire logic                      st_wdog_i,
  input  wire logic                      st_late_col_i,
  input  wire logic                      st_giant_i,
  input  wire logic                      st_vlan_i,
  input  wire logic                      st_ctrl_frame_i,
  input  wire logic                      st_len_mismatch_i,
  input  wire logic                      st_ip_hdr_err_i,
  input  wire logic                      st_ip_pay_err_i,
  input  wire logic                      st_overflow_i,
  input  wire logic [15:0]               st_len_type_i,
  output logic                           wb0_valid_o,
  output logic      [31:0]               wb0_word_o
);

  typedef enum logic [3:0] {
    ST_FETCH = 4'b0001,
    ST_RECV  = 4'b0010,
    ST_NEXT  = 4'b0100,
    ST_DROP  = 4'b1000
  } rdw_state_t;

  typedef struct packed {
    rdw_state_t                 state;
    logic [rdw_pkg::LEN_W-1:0]  cap;
    logic [rdw_pkg::LEN_W-1:0]  used;
    logic [rdw_pkg::LEN_W-1:0]  frame_cnt;
    logic                       first;
    logic                       in_frame;
    logic                       wb_valid;
    logic [31:0]                word;
    logic [15:0]                frames;
    logic [15:0]                truncs;
  } rdw_core_state_t;

  rdw_core_state_t       s_reg;
  rdw_core_state_t       s_next;
  rdw_pkg::rdw_fields_t  fld;
  logic [31:0]           packed_word;
  logic                  beat;
  logic                  desc_zero;
  logic                  keep_frame;
  logic [rdw_pkg::LEN_W-1:0] cnt_inc;

  rdw_cfg_if cfg ();

  rdw_wb_regs u_regs (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .cfg      (cfg)
  );

  rdw_word_pack u_pack (
    .f_i    (fld),
    .word_o (packed_word)
  );

  // total of both buffer sizes; 13 bit sizes always fit the 14 bit length field
  function automatic logic [rdw_pkg::LEN_W-1:0] buf_cap(input logic [rdw_pkg::BS_W-1:0] a,
                                                         input logic [rdw_pkg::BS_W-1:0] b);
    return {1'b0, a} + {1'b0, b};
  endfunction

  // handshakes: descriptors taken only while enabled and waiting for one, bytes while receiving or swallowing a truncated rest
  assign desc_ready_o = cfg.enable & (s_reg.state == ST_FETCH || s_reg.state == ST_NEXT);
  assign rx_ready_o   = (s_reg.state == ST_RECV) || (s_reg.state == ST_DROP);
  assign beat         = rx_valid_i & rx_ready_o;
  assign desc_zero    = (desc_bs1_i == '0) && (desc_bs2_i == '0);
  assign cnt_inc      = s_reg.frame_cnt + rdw_pkg::LEN_ONE;
  // store and forward drops an overflowed frame only while it is still in its first descriptor
  assign keep_frame   = cfg.threshold_mode | ~st_overflow_i;

  // fields of the word written at a frame's end; masks keep flags within their meaning
  always_comb begin
    fld          = '0;
    fld.own      = 1'b0;
    fld.da_fail  = st_da_fail_i;
    fld.len      = cnt_inc;
    if (cfg.ipc_type1 && !st_ctrl_frame_i) begin
      fld.len    = cnt_inc + rdw_pkg::IPC_T1_EXTRA;
    end
    fld.sa_fail  = st_sa_fail_i;
    fld.etype    = (st_len_type_i >= rdw_pkg::ETHERTYPE_MIN);
    fld.len_err  = st_len_mismatch_i & ~fld.etype;
    fld.ovf      = st_overflow_i & cfg.threshold_mode;
    fld.vlan     = st_vlan_i;
    fld.first    = s_reg.first;
    fld.last     = 1'b1;
    fld.giant    = st_giant_i;
    fld.late_col = st_late_col_i;
    fld.wdog     = st_wdog_i;
    fld.rx_err   = st_rx_err_i;
    fld.crc      = st_crc_err_i;
    fld.ip_hdr   = st_ip_hdr_err_i;
    fld.ip_pay   = st_ip_pay_err_i;
  end

  // descriptor walk; a full descriptor is held back until the next one is known,
  // so a truncation can still be flagged in it as the frame's last
  always_comb begin
    s_next          = s_reg;
    s_next.wb_valid = 1'b0;
    unique case (s_reg.state)
      ST_FETCH: begin
        if (desc_ready_o && desc_valid_i && desc_own_i) begin
          if (desc_zero) begin
            s_next.wb_valid = 1'b1;
            s_next.word     = 32'h0000_0000;
          end else begin
            s_next.cap      = buf_cap(desc_bs1_i, desc_bs2_i);
            s_next.used     = '0;
            s_next.frame_cnt = '0;
            s_next.first    = 1'b1;
            s_next.in_frame = 1'b0;
            s_next.state    = ST_RECV;
          end
        end
      end
      ST_RECV: begin
        if (beat) begin
          s_next.used      = s_reg.used + rdw_pkg::LEN_ONE;
          s_next.frame_cnt = cnt_inc;
          s_next.in_frame  = 1'b1;
          if (rx_last_i && !keep_frame && s_reg.first) begin
            // dropped frame: the same descriptor waits for the next frame
            s_next.used      = '0;
            s_next.frame_cnt = '0;
            s_next.in_frame  = 1'b0;
          end else if (rx_last_i) begin
            s_next.wb_valid = 1'b1;
            s_next.word     = packed_word;
            s_next.frames   = s_reg.frames + rdw_pkg::STAT_ONE;
            s_next.state    = ST_FETCH;
          end else if (s_next.used == s_reg.cap) begin
            // running count, not last, no error summary
            s_next.word  = {1'b0, 1'b0, cnt_inc, 6'h00, s_reg.first, 9'h000};
            s_next.state = ST_NEXT;
          end
        end
      end
      ST_NEXT: begin
        if (desc_ready_o && desc_valid_i) begin
          if (!desc_own_i) begin
            s_next.wb_valid = 1'b1;
            s_next.word     = s_reg.word;
            s_next.word[rdw_pkg::LAST_BIT]    = 1'b1;
            s_next.word[rdw_pkg::TRUNC_BIT]   = 1'b1;
            s_next.word[rdw_pkg::ERR_ANY_BIT] = 1'b1;
            s_next.truncs   = s_reg.truncs + rdw_pkg::STAT_ONE;
            s_next.state    = ST_DROP;
          end else if (desc_zero) begin
            s_next.state = ST_NEXT;
          end else begin
            s_next.wb_valid = 1'b1;
            s_next.cap      = buf_cap(desc_bs1_i, desc_bs2_i);
            s_next.used     = '0;
            s_next.first    = 1'b0;
            s_next.state    = ST_RECV;
          end
        end
      end
      ST_DROP: begin
        // truncated remainder is swallowed up to the frame end
        if (beat && rx_last_i) begin
          s_next.state = ST_FETCH;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '{state: ST_FETCH, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb0_valid_o      = s_reg.wb_valid;
  assign wb0_word_o       = s_reg.word;
  assign cfg.frames_done  = s_reg.frames;
  assign cfg.trunc_count  = s_reg.truncs;
  assign cfg.last_word    = s_reg.word;

  // checks on the written word and the descriptor walk
  a_own_returned: assert property (@(posedge clk_i) disable iff (rst_i)
    wb0_valid_o |-> !wb0_word_o[31]) else $error("written word still owned");
  a_trunc_in_last: assert property (@(posedge clk_i) disable iff (rst_i)
    wb0_valid_o && wb0_word_o[14] |-> wb0_word_o[8] && wb0_word_o[15])
    else $error("truncation outside last word");
  a_nonlast_clean: assert property (@(posedge clk_i) disable iff (rst_i)
    wb0_valid_o && !wb0_word_o[8] |-> !wb0_word_o[15] && !wb0_word_o[14])
    else $error("error summary in non-last word");
  a_unowned_stall: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.state == ST_FETCH && desc_valid_i && !desc_own_i |=>
    !wb0_valid_o && s_reg.state == ST_FETCH) else $error("host descriptor used");
  a_etype_decode: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.state == ST_RECV && beat && rx_last_i && keep_frame |=>
    wb0_valid_o && wb0_word_o[5] == ($past(st_len_type_i) >= 16'h0600))
    else $error("frame type bit wrong");
  a_len_final: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.state == ST_RECV && beat && rx_last_i && keep_frame && !cfg.ipc_type1 |=>
    wb0_word_o[29:16] == $past(s_reg.frame_cnt) + 14'h0001)
    else $error("final length wrong");
  // only a taken descriptor moves the walk on, so ready is part of every hand-over check
  a_running_len: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.state == ST_NEXT && desc_ready_o && desc_valid_i && desc_own_i && !desc_zero |=>
    wb0_valid_o && !wb0_word_o[8] && wb0_word_o[29:16] == $past(s_reg.frame_cnt))
    else $error("running count wrong");
  a_ovf_thresh: assert property (@(posedge clk_i) disable iff (rst_i)
    wb0_valid_o && wb0_word_o[11] |-> cfg.threshold_mode)
    else $error("overflow flag outside threshold mode");
  a_first_once: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.state == ST_NEXT && desc_ready_o && desc_valid_i && desc_own_i && !desc_zero |=>
    s_reg.state == ST_RECV && !s_reg.first)
    else $error("first flag repeated");
  a_first_set: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.state == ST_FETCH && desc_ready_o && desc_valid_i && desc_own_i && !desc_zero |=>
    s_reg.state == ST_RECV && s_reg.first) else $error("first flag missing");
  a_zero_word: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.state == ST_FETCH && desc_ready_o && desc_valid_i && desc_own_i && desc_zero |=>
    wb0_valid_o && wb0_word_o == 32'h0000_0000) else $error("empty descriptor word wrong");

  // frame end fields; the checksum bytes ride on top of the counted bytes
  a_len_ipc: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.state == ST_RECV && beat && rx_last_i && keep_frame && cfg.ipc_type1 &&
    !st_ctrl_frame_i |=> wb0_word_o[29:16] == $past(s_reg.frame_cnt) + 14'h0003)
    else $error("checksum length wrong");
  a_filter_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.state == ST_RECV && beat && rx_last_i && keep_frame |=> wb0_valid_o && wb0_word_o[8] &&
    wb0_word_o[30] == $past(st_da_fail_i) && wb0_word_o[13] == $past(st_sa_fail_i) &&
    wb0_word_o[10] == $past(st_vlan_i)) else $error("filter or vlan flag wrong");
  a_err_summary: assert property (@(posedge clk_i) disable iff (rst_i)
    wb0_valid_o && wb0_word_o[8] && (|{wb0_word_o[14], wb0_word_o[11], wb0_word_o[7:6],
    wb0_word_o[4:3], wb0_word_o[1]}) |-> wb0_word_o[15]) else $error("error summary missing");
  a_len_err_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    wb0_valid_o && wb0_word_o[12] |-> !wb0_word_o[5]) else $error("length error on type frame");
  a_sf_no_word: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.state == ST_RECV && beat && rx_last_i && !keep_frame && s_reg.first |=>
    !wb0_valid_o && s_reg.state == ST_RECV) else $error("overflowed frame handed on");

  // scenarios the bench is expected to reach
  c_ipc_len:    cover property (@(posedge clk_i) disable iff (rst_i)
    wb0_valid_o && wb0_word_o[8] && cfg.ipc_type1);
  c_truncate:   cover property (@(posedge clk_i) disable iff (rst_i)
    wb0_valid_o && wb0_word_o[14]);
  c_span:       cover property (@(posedge clk_i) disable iff (rst_i)
    wb0_valid_o && wb0_word_o[8] && !wb0_word_o[9]);
  c_zero_skip:  cover property (@(posedge clk_i) disable iff (rst_i)
    s_reg.state == ST_FETCH && desc_valid_i && desc_own_i && desc_zero);
  c_sf_drop:    cover property (@(posedge clk_i) disable iff (rst_i)
    s_reg.state == ST_RECV && beat && rx_last_i && !keep_frame);

endmodule // rdw_status_core

// File: rdw_desc_model.sv
// descriptor fetcher model: presents receive descriptors, dma or host owned, to the core
`timescale 1ns/1ps
module rdw_desc_model (
  input  wire logic                     clk_i,
  input  wire logic                     desc_ready_i,
  output logic                          desc_valid_o,
  output logic                          desc_own_o,
  output logic [rdw_pkg::BS_W-1:0]      desc_bs1_o,
  output logic [rdw_pkg::BS_W-1:0]      desc_bs2_o
);
  // idle until the bench hands over the first descriptor
  initial begin
    desc_valid_o = 1'b0;
    desc_own_o   = 1'b0;
    desc_bs1_o   = '0;
    desc_bs2_o   = '0;
  end

  // sizes are presented together with the own bit, never changed while offered
  task automatic give(input logic own, input logic [rdw_pkg::BS_W-1:0] bs1,
                      input logic [rdw_pkg::BS_W-1:0] bs2);
    @(posedge clk_i);
    desc_valid_o <= 1'b1;
    desc_own_o   <= own;
    desc_bs1_o   <= bs1;
    desc_bs2_o   <= bs2;
    @(posedge clk_i);
    while (desc_ready_i !== 1'b1) @(posedge clk_i);
    desc_valid_o <= 1'b0;
    // released fields show inverted junk so a late read cannot pass by luck
    desc_own_o   <= ~own;
    desc_bs1_o   <= ~bs1;
    desc_bs2_o   <= ~bs2;
  endtask
endmodule // rdw_desc_model

// File: test_rx_descriptor_status_word0.sv
// self-checking bench for the receive descriptor status word writer
`timescale 1ns/1ps
module test_rx_descriptor_status_word0;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0, wb_dat_o, wb0_word_o;
  logic        wb_ack_o, desc_ready_o, rx_ready_o, wb0_valid_o;
  logic        desc_valid, desc_own, rx_valid = 1'b0, rx_last = 1'b0;
  logic [12:0] bs1, bs2, st = 13'h0;
  logic [15:0] lt = 16'h0;
  logic [31:0] q[$];
  int          errors = 0, compares = 0;

  rdw_status_core i_rdw_status_core (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .desc_ready_o(desc_ready_o), .desc_valid_i(desc_valid),
    .desc_own_i(desc_own), .desc_bs1_i(bs1), .desc_bs2_i(bs2), .rx_valid_i(rx_valid),
    .rx_ready_o(rx_ready_o), .rx_last_i(rx_last), .st_overflow_i(st[12]), .st_da_fail_i(st[11]),
    .st_sa_fail_i(st[10]), .st_crc_err_i(st[9]), .st_rx_err_i(st[8]), .st_wdog_i(st[7]),
    .st_late_col_i(st[6]), .st_giant_i(st[5]), .st_vlan_i(st[4]), .st_ctrl_frame_i(st[3]),
    .st_len_mismatch_i(st[2]), .st_ip_hdr_err_i(st[1]), .st_ip_pay_err_i(st[0]),
    .st_len_type_i(lt), .wb0_valid_o(wb0_valid_o), .wb0_word_o(wb0_word_o));

  rdw_desc_model i_rdw_desc_model (.clk_i(clk), .desc_ready_i(desc_ready_o),
    .desc_valid_o(desc_valid), .desc_own_o(desc_own), .desc_bs1_o(bs1), .desc_bs2_o(bs2));

  // 125 MHz clock
  initial begin
    forever #4 clk = ~clk;
  end

  // every write-back pulse is queued so no word is missed while stimulus runs
  always @(posedge clk) begin
    if (wb0_valid_o === 1'b1) q.push_back(wb0_word_o);
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // classic wishbone cycle; ack is awaited, never assumed
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] rd);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hf; dat <= d;
    @(posedge clk);
    while (wb_ack_o !== 1'b1) @(posedge clk);
    rd = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic setc(input logic [31:0] v);
    logic [31:0] rd;
    wb(1'b1, rdw_pkg::OFF_CTRL, v, rd);
  endtask

  // one byte per accepted beat; status rides on the last beat only
  task automatic frame(input int n, input logic [12:0] s, input logic [15:0] t);
    for (int i = 0; i < n; i++) begin
      rx_valid <= 1'b1;
      rx_last  <= (i == n - 1);
      st       <= (i == n - 1) ? s : 13'h0;
      lt       <= t;
      @(posedge clk);
      while (rx_ready_o !== 1'b1) @(posedge clk);
    end
    rx_valid <= 1'b0;
    rx_last  <= 1'b0;
    st       <= 13'h0;
  endtask

  // bounded wait for the next written word, then compare
  task automatic chk(input logic [31:0] exp);
    logic [31:0] got;
    got = 'x;
    for (int n = 0; n < 100 && q.size() == 0; n++) @(posedge clk);
    if (q.size() != 0) got = q.pop_front();
    cmp(got, exp);
  endtask

  task automatic t_regs;
    logic [31:0] rd;
    wb(1'b0, rdw_pkg::OFF_CTRL, 32'h0, rd);
    cmp(rd, 32'h0);
    wb(1'b1, 4'hc, 32'h7, rd);
    wb(1'b0, 4'hc, 32'h0, rd);
    cmp(rd, 32'h0);
    setc(32'h1);
    wb(1'b0, rdw_pkg::OFF_CTRL, 32'h0, rd);
    cmp(rd, 32'h1);
  endtask

  task automatic t_basic;
    i_rdw_desc_model.give(1'b1, 13'h8, 13'h0);
    frame(3, 13'h0c10, 16'h0600);
    chk(32'h40032720);
    i_rdw_desc_model.give(1'b1, 13'h0, 13'h0);
    chk(32'h0);
    setc(32'h3);
    i_rdw_desc_model.give(1'b1, 13'h0, 13'h8);
    frame(4, 13'h0224, 16'h0040);
    chk(32'h00069382);
    i_rdw_desc_model.give(1'b1, 13'h8, 13'h0);
    frame(2, 13'h0008, 16'h8808);
    chk(32'h00020320);
  endtask

  // each status error input except overflow and length mismatch alone must raise the summary
  task automatic t_errors;
    logic [12:0] e[7] = '{13'h200, 13'h100, 13'h080, 13'h040, 13'h020, 13'h002, 13'h001};
    logic [31:0] b[7] = '{32'h2, 32'h8, 32'h10, 32'h40, 32'h80, 32'h0, 32'h0};
    setc(32'h1);
    for (int i = 0; i < 7; i++) begin
      i_rdw_desc_model.give(1'b1, 13'h8, 13'h0);
      frame(1, e[i], 16'h0040);
      chk(32'h00018300 | b[i]);
    end
  endtask

  task automatic t_fill;
    i_rdw_desc_model.give(1'b1, 13'h2, 13'h0);
    fork
      frame(3, 13'h0, 16'h0600);
      i_rdw_desc_model.give(1'b1, 13'h4, 13'h0);
    join
    chk(32'h00020200);
    chk(32'h00030120);
    i_rdw_desc_model.give(1'b1, 13'h1, 13'h0);
    fork
      frame(3, 13'h0, 16'h0600);
      i_rdw_desc_model.give(1'b0, 13'h4, 13'h0);
    join
    chk(32'h0001c300);
  endtask

  task automatic t_ovf;
    logic [31:0] rd;
    i_rdw_desc_model.give(1'b1, 13'h8, 13'h0);
    frame(2, 13'h1000, 16'h0600);
    repeat (10) @(posedge clk);
    cmp(32'(q.size()), 32'h0);
    setc(32'h5);
    frame(2, 13'h1000, 16'h0600);
    chk(32'h00028b20);
    wb(1'b0, rdw_pkg::OFF_LAST_WORD, 32'h0, rd);
    cmp(rd, 32'h00028b20);
    wb(1'b0, rdw_pkg::OFF_STATS, 32'h0, rd);
    cmp(rd, 32'h0001000c);
  endtask

  task automatic test_done;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_basic;
    t_errors;
    t_fill;
    t_ovf;
    test_done;
  end

  // hang guard: far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done;
  end
endmodule // test_rx_descriptor_status_word0
